/* File: hw/adc_pkg.sv */
// package: register map, field layout, timing constants and carriers for the async dram block
package adc_pkg;
  localparam logic [11:0] OFS_CTRL  = 12'h100;
  localparam logic [11:0] OFS_BLK0  = 12'h108;
  localparam logic [11:0] OFS_MASK0 = 12'h10c;
  localparam logic [11:0] OFS_BLK1  = 12'h110;
  localparam logic [11:0] OFS_MASK1 = 12'h114;
  localparam logic [11:0] OFS_STAT  = 12'h118;
  localparam int CTRL_SYNC = 15;
  localparam int CTRL_NAM  = 13;
  localparam int CTRL_RRA  = 11;
  localparam int CTRL_RRP  = 9;
  localparam int CTRL_RC   = 0;
  localparam int BLK_BA    = 18;
  localparam int BLK_RE    = 15;
  localparam int BLK_CAS   = 12;
  localparam int BLK_RP    = 10;
  localparam int BLK_RNE   = 9;
  localparam int BLK_RCD   = 8;
  localparam int BLK_EDO   = 6;
  localparam int BLK_PS    = 4;
  localparam int BLK_PM    = 2;
  localparam int MASK_VALID = 0;
  localparam logic [31:0] CTRL_WMASK = 32'h0000bfff;
  localparam logic [31:0] BLK_WMASK  = 32'hfffcbf7c;
  localparam logic [31:0] MASK_WMASK = 32'hfffc0001;
  localparam logic [31:0] RESET_VAL  = 32'h00000000;
  localparam int REF_SHIFT = 4;
  localparam int REF_RRA_BASE = 2;
  localparam int CYC_BASE = 1;
  localparam logic [1:0] PS_32 = 2'h0;
  localparam logic [1:0] PS_8  = 2'h1;
  localparam logic [1:0] PM_RESERVED = 2'h2;
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
  } adc_access_t;
  typedef struct packed {
    logic [1:0] hit;
    logic       busy;
    logic       refreshing;
    logic       ref_pend;
  } adc_status_t;
endpackage : adc_pkg

/* File: hw/adc_refresh_timer.sv */
// shared refresh interval counter
`timescale 1ns/1ps
`default_nettype none
module adc_refresh_timer #(
  parameter int CW = 9
) (
  // clocking
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  // setup and request
  input  wire logic [CW-1:0] count,
  input  wire logic          enable,
  output logic               tick
);
  localparam int TW = CW + adc_pkg::REF_SHIFT;
  logic [TW-1:0] cnt_r;
  logic [TW-1:0] limit;
  // interval is (count+1)*16 clocks
  assign limit = {count, {adc_pkg::REF_SHIFT{1'b1}}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (!enable) begin
        cnt_r <= '0;
      end else if (cnt_r >= limit) begin
        cnt_r <= '0;
        tick  <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  a_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    ce && enable && cnt_r == limit |=> tick)
    else $error("refresh tick missing at interval end");
endmodule : adc_refresh_timer
`default_nettype wire

/* File: hw/adc_block_hit.sv */
// address hit decode for one dram block
`timescale 1ns/1ps
`default_nettype none
module adc_block_hit (
  // configuration
  input  wire logic [31:0] blk_cfg,
  input  wire logic [31:0] mask_cfg,
  // bus address
  input  wire logic [31:0] addr,
  output logic             hit
);
  localparam int BW = 32 - adc_pkg::BLK_BA;
  logic [BW-1:0] diff;
  // set mask bits drop out of the compare
  assign diff = (blk_cfg[31:adc_pkg::BLK_BA] ^ addr[31:adc_pkg::BLK_BA])
              & ~mask_cfg[31:adc_pkg::BLK_BA];
  assign hit = mask_cfg[adc_pkg::MASK_VALID] && (diff == '0);
endmodule : adc_block_hit
`default_nettype wire

/* File: hw/adc_ctrl.sv */
// async dram configuration, refresh sequencing and strobe timing
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl #(
  parameter int RC_W = 9
) (
  // clocking
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // processor access request
  input  wire logic        acc_req,
  input  wire logic        acc_write,
  input  wire logic [31:0] acc_addr,
  output logic             acc_done,
  // dram pins
  output logic [1:0]       ras_n,
  output logic [3:0]       cas_n,
  output logic             dram_we_n,
  output logic             col_mux,
  // configuration status
  output logic             sync_mode,
  output logic [1:0]       blk_port_size0,
  output logic [1:0]       blk_port_size1,
  output logic [1:0]       blk_edo
);
  logic [31:0] ctrl_r, blk0_r, blk1_r, mask0_r, mask1_r;
  logic [1:0]  hit;
  logic        tick;
  logic        ref_pend_r;
  logic [2:0]  cnt_r;
  logic        sel_r;
  adc_pkg::adc_access_t acc_in;
  adc_pkg::adc_status_t stat;

  typedef enum {ST_IDLE, ST_RCD, ST_CAS, ST_PRE, ST_REF, ST_REF_PRE} adc_state_t;
  adc_state_t state_r;

  function automatic logic [2:0] code_cycles(input logic [1:0] code, input int base);
    code_cycles = 3'(code) + 3'(base);
  endfunction : code_cycles

  function automatic logic [31:0] wr_field(input logic [31:0] old, input logic [31:0] d,
                                           input logic [31:0] m);
    wr_field = (old & ~m) | (d & m);
  endfunction : wr_field

  assign acc_in = '{req: acc_req, write: acc_write, addr: acc_addr};

  adc_block_hit u_hit0 (.blk_cfg(blk0_r), .mask_cfg(mask0_r), .addr(acc_in.addr), .hit(hit[0]));
  adc_block_hit u_hit1 (.blk_cfg(blk1_r), .mask_cfg(mask1_r), .addr(acc_in.addr), .hit(hit[1]));

  // one counter for both blocks
  adc_refresh_timer #(.CW(RC_W)) u_ref (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .count(ctrl_r[adc_pkg::CTRL_RC +: RC_W]),
    .enable(blk0_r[adc_pkg::BLK_RE] | blk1_r[adc_pkg::BLK_RE]),
    .tick(tick)
  );

  logic wr_en, rd_en;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // register writes; sync mode is sticky until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= adc_pkg::RESET_VAL;
      blk0_r  <= adc_pkg::RESET_VAL;
      blk1_r  <= adc_pkg::RESET_VAL;
      mask0_r <= adc_pkg::RESET_VAL;
      mask1_r <= adc_pkg::RESET_VAL;
    end else if (ce && wr_en) begin
      case (paddr)
        adc_pkg::OFS_CTRL: begin
          ctrl_r <= wr_field(ctrl_r, pwdata, adc_pkg::CTRL_WMASK);
          if (ctrl_r[adc_pkg::CTRL_SYNC]) ctrl_r[adc_pkg::CTRL_SYNC] <= 1'b1;
        end
        // reserved page code is kept out of the register
        adc_pkg::OFS_BLK0: if (pwdata[adc_pkg::BLK_PM +: 2] != adc_pkg::PM_RESERVED)
                             blk0_r <= wr_field(blk0_r, pwdata, adc_pkg::BLK_WMASK);
        adc_pkg::OFS_BLK1: if (pwdata[adc_pkg::BLK_PM +: 2] != adc_pkg::PM_RESERVED)
                             blk1_r <= wr_field(blk1_r, pwdata, adc_pkg::BLK_WMASK);
        adc_pkg::OFS_MASK0: mask0_r <= wr_field(mask0_r, pwdata, adc_pkg::MASK_WMASK);
        adc_pkg::OFS_MASK1: mask1_r <= wr_field(mask1_r, pwdata, adc_pkg::MASK_WMASK);
        default: ;
      endcase
    end
  end

  logic known;
  always_comb begin
    case (paddr)
      adc_pkg::OFS_CTRL, adc_pkg::OFS_BLK0, adc_pkg::OFS_MASK0,
      adc_pkg::OFS_BLK1, adc_pkg::OFS_MASK1, adc_pkg::OFS_STAT: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // apb answers in the access cycle, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !known;
      if (rd_en) begin
        case (paddr)
          adc_pkg::OFS_CTRL:  prdata <= ctrl_r;
          adc_pkg::OFS_BLK0:  prdata <= blk0_r;
          adc_pkg::OFS_MASK0: prdata <= mask0_r;
          adc_pkg::OFS_BLK1:  prdata <= blk1_r;
          adc_pkg::OFS_MASK1: prdata <= mask1_r;
          adc_pkg::OFS_STAT:  prdata <= {27'h0000000, stat};
          default:            prdata <= '0;
        endcase
      end
    end
  end

  assign stat = '{hit: hit, busy: (state_r != ST_IDLE),
                  refreshing: (state_r == ST_REF), ref_pend: ref_pend_r};

  // refresh request held until the sequencer is idle, then taken, or dropped in sync mode; a new tick wins over the take
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_pend_r <= 1'b0;
    end else if (ce) begin
      if (tick) ref_pend_r <= 1'b1;
      else if (state_r == ST_IDLE && ref_pend_r) ref_pend_r <= 1'b0;
    end
  end

  logic [31:0] cur;
  assign cur = sel_r ? blk1_r : blk0_r;
  logic short_cas;
  assign short_cas = cur[adc_pkg::BLK_CAS +: 2] == 2'h0;

  // access and refresh sequencer; refresh only starts from idle, after precharge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r  <= ST_IDLE;
      cnt_r    <= '0;
      sel_r    <= 1'b0;
      acc_done <= 1'b0;
    end else if (ce) begin
      acc_done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (ref_pend_r && !ctrl_r[adc_pkg::CTRL_SYNC]) begin
            state_r <= ST_REF;
            cnt_r   <= code_cycles(ctrl_r[adc_pkg::CTRL_RRA +: 2], adc_pkg::REF_RRA_BASE);
          end else if (acc_in.req && |hit && !ctrl_r[adc_pkg::CTRL_SYNC]) begin
            sel_r   <= hit[1];
            state_r <= ST_RCD;
            cnt_r   <= {2'h0, (hit[1] ? blk1_r[adc_pkg::BLK_RCD] : blk0_r[adc_pkg::BLK_RCD])} + 3'h1;
          end
        end
        ST_RCD: begin
          if (cnt_r <= 3'h1) begin
            state_r <= ST_CAS;
            cnt_r   <= code_cycles(cur[adc_pkg::BLK_CAS +: 2], adc_pkg::CYC_BASE);
          end else cnt_r <= cnt_r - 3'h1;
        end
        ST_CAS: begin
          if (cnt_r <= 3'h1) begin
            state_r  <= ST_PRE;
            acc_done <= 1'b1;
            cnt_r    <= code_cycles(cur[adc_pkg::BLK_RP +: 2], adc_pkg::CYC_BASE);
          end else cnt_r <= cnt_r - 3'h1;
        end
        ST_PRE, ST_REF_PRE: begin
          if (cnt_r <= 3'h1) state_r <= ST_IDLE;
          else cnt_r <= cnt_r - 3'h1;
        end
        ST_REF: begin
          if (cnt_r <= 3'h1) begin
            state_r <= ST_REF_PRE;
            cnt_r   <= code_cycles(ctrl_r[adc_pkg::CTRL_RRP +: 2], adc_pkg::CYC_BASE);
          end else cnt_r <= cnt_r - 3'h1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // strobes update on the falling edge, from the sequencer state
  logic [1:0] ras_nxt;
  logic       cas_nxt;
  always_comb begin
    ras_nxt = 2'h3;
    cas_nxt = 1'b0;
    case (state_r)
      ST_RCD: ras_nxt[sel_r] = 1'b0;
      ST_CAS: begin
        cas_nxt = 1'b1;
        // early row negate in last column clock, page mode code 0 only, not for single-clock column
        if (!(cur[adc_pkg::BLK_RNE] && !short_cas && cnt_r <= 3'h1
              && cur[adc_pkg::BLK_PM +: 2] == 2'h0)) ras_nxt[sel_r] = 1'b0;
      end
      ST_REF: ras_nxt = ~{blk1_r[adc_pkg::BLK_RE], blk0_r[adc_pkg::BLK_RE]};
      default: ;
    endcase
  end

  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      ras_n     <= 2'h3;
      cas_n     <= 4'hf;
      dram_we_n <= 1'b1;
    end else if (ce) begin
      ras_n     <= ras_nxt;
      cas_n     <= cas_nxt ? 4'h0 : 4'hf;
      dram_we_n <= !(cas_nxt && acc_in.write);
    end
  end

  // configuration outputs registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_mux        <= 1'b0;
      sync_mode      <= 1'b0;
      blk_port_size0 <= adc_pkg::PS_32;
      blk_port_size1 <= adc_pkg::PS_32;
      blk_edo        <= 2'h0;
    end else if (ce) begin
      col_mux        <= (state_r == ST_CAS) && !ctrl_r[adc_pkg::CTRL_NAM];
      sync_mode      <= ctrl_r[adc_pkg::CTRL_SYNC];
      blk_port_size0 <= blk0_r[adc_pkg::BLK_PS +: 2];
      blk_port_size1 <= blk1_r[adc_pkg::BLK_PS +: 2];
      blk_edo        <= {blk1_r[adc_pkg::BLK_EDO], blk0_r[adc_pkg::BLK_EDO]};
    end
  end

  a_sync_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_r[adc_pkg::CTRL_SYNC] |=> ctrl_r[adc_pkg::CTRL_SYNC])
    else $error("sync mode left without reset");
  a_nam_nomux: assert property (@(posedge pclk) disable iff (!presetn)
    ce && ctrl_r[adc_pkg::CTRL_NAM] && $stable(ctrl_r) |=> !col_mux)
    else $error("column mux active with no-mux set");
  a_ref_waits: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_PRE |=> state_r != ST_REF)
    else $error("refresh entered during precharge");
  a_ref_len: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_r == ST_IDLE && ref_pend_r && !ctrl_r[adc_pkg::CTRL_SYNC]
      && ctrl_r[adc_pkg::CTRL_RRA +: 2] == 2'h0 |=> cnt_r == 3'h2)
    else $error("refresh row strobe length wrong");
  a_rrp_len: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_r == ST_REF && cnt_r <= 3'h1 |=>
      cnt_r == code_cycles(ctrl_r[adc_pkg::CTRL_RRP +: 2], adc_pkg::CYC_BASE))
    else $error("refresh precharge length wrong");
  a_hit_valid: assert property (@(posedge pclk) disable iff (!presetn)
    !mask0_r[adc_pkg::MASK_VALID] |-> !hit[0])
    else $error("hit on invalid block");
  a_cas_len: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_r == ST_RCD && cnt_r <= 3'h1 |=>
      cnt_r == code_cycles(cur[adc_pkg::BLK_CAS +: 2], adc_pkg::CYC_BASE))
    else $error("column strobe length wrong");
  a_no_reserved_pm: assert property (@(posedge pclk) disable iff (!presetn)
    blk0_r[adc_pkg::BLK_PM +: 2] != adc_pkg::PM_RESERVED)
    else $error("reserved page mode stored");
endmodule : adc_ctrl
`default_nettype wire

/* File: verif/adc_dram_model.sv */
// observer model of the dram devices, timing the strobes in clocks
`timescale 1ns/1ps
`default_nettype none
module adc_dram_model #(
  parameter int PERIOD = 8
) (
  // dram strobes
  input  wire logic       pclk,
  input  wire logic [1:0] ras_n,
  input  wire logic [3:0] cas_n,
  // measured timings, in clocks
  output var int          ras_low,
  output var int          ras_gap,
  output var int          rcd_clk,
  output var int          cas_low,
  output var int          pair_falls,
  output var int          odd_edges
);
  time t_rf;
  time t_cf;
  initial begin
    t_rf = 0;
    t_cf = 0;
    ras_low = 0;
    ras_gap = 0;
    rcd_clk = 0;
    cas_low = 0;
    pair_falls = 0;
    odd_edges = 0;
  end
  // the devices only look at the strobes; they drive nothing back
  always @(negedge ras_n[0]) begin
    ras_gap = int'(($time - t_rf) / PERIOD);
    t_rf = $time;
    if (ras_n[1] === 1'b0) pair_falls = pair_falls + 1;
  end
  always @(posedge ras_n[0]) ras_low = int'(($time - t_rf) / PERIOD);
  always @(negedge cas_n[0]) begin
    t_cf = $time;
    rcd_clk = int'((t_cf - t_rf) / PERIOD);
  end
  always @(posedge cas_n[0]) cas_low = int'(($time - t_cf) / PERIOD);
  // a strobe edge while the clock is high came from the wrong edge
  always @(ras_n or cas_n) if (pclk === 1'b1) odd_edges = odd_edges + 1;
endmodule : adc_dram_model
`default_nettype wire

/* File: verif/adc_ctrl_bench.sv */
// self-checking bench for the async dram block controller
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        acc_req, acc_write, acc_done, col_mux, sync_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, acc_addr;
  logic [1:0]  ras_n, blk_port_size0, blk_edo;
  logic [3:0]  cas_n;
  int          ras_low, ras_gap, rcd_clk, cas_low, pair_falls, odd_edges;
  int          fail_count = 0;
  int          comparisons = 0;
  adc_ctrl u_adc_ctrl (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_req(acc_req), .acc_write(acc_write), .acc_addr(acc_addr), .acc_done(acc_done), .ras_n(ras_n),
    .cas_n(cas_n), .dram_we_n(), .col_mux(col_mux), .sync_mode(sync_mode),
    .blk_port_size0(blk_port_size0), .blk_port_size1(), .blk_edo(blk_edo));
  adc_dram_model u_adc_dram_model (.pclk(pclk), .ras_n(ras_n), .cas_n(cas_n), .ras_low(ras_low),
    .ras_gap(ras_gap), .rcd_clk(rcd_clk), .cas_low(cas_low), .pair_falls(pair_falls), .odd_edges(odd_edges));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fail_count++;
      final_report();
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b1, d, q, e);
    @(posedge pclk);
    // registered copies of the register bits settle after this edge
    @(negedge pclk);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(a, 1'b0, 32'h0, q, e);
    chk(q, exp);
  endtask : rd_chk
  // a refused request is withdrawn after a bounded wait
  task automatic acc(input logic [31:0] a, input logic w, output logic ok, output logic mux);
    ok = 1'b0;
    mux = 1'b0;
    @(posedge pclk);
    acc_req <= 1'b1;
    acc_write <= w;
    acc_addr <= a;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(posedge pclk);
      if (col_mux === 1'b1) mux = 1'b1;
      if (acc_done === 1'b1) ok = 1'b1;
    end
    acc_req <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask : acc
  task automatic t_regs();
    logic [31:0] q;
    logic        e;
    logic [11:0] ofs [6] = '{adc_pkg::OFS_CTRL, adc_pkg::OFS_BLK0, adc_pkg::OFS_MASK0,
                             adc_pkg::OFS_BLK1, adc_pkg::OFS_MASK1, adc_pkg::OFS_STAT};
    foreach (ofs[i]) rd_chk(ofs[i], adc_pkg::RESET_VAL);
    wr(adc_pkg::OFS_BLK0, 32'hfffffff3);
    rd_chk(adc_pkg::OFS_BLK0, 32'hfffcbf70);
    wr(adc_pkg::OFS_BLK0, 32'h00000008);
    rd_chk(adc_pkg::OFS_BLK0, 32'hfffcbf70);
    wr(adc_pkg::OFS_CTRL, 32'h00007fff);
    rd_chk(adc_pkg::OFS_CTRL, 32'h00003fff);
    apb(12'h104, 1'b0, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(adc_pkg::OFS_CTRL, 32'h0);
  endtask : t_regs
  task automatic t_port();
    for (int p = 0; p < 4; p++) begin
      wr(adc_pkg::OFS_BLK0, 32'((p << adc_pkg::BLK_PS) | ((p & 1) << adc_pkg::BLK_EDO)));
      chk({30'h0, blk_port_size0}, 32'(p));
      chk({31'h0, blk_edo[0]}, 32'(p & 1));
    end
  endtask : t_port
  task automatic t_access();
    logic ok, mux;
    wr(adc_pkg::OFS_MASK0, 32'h1);
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 2; r++) begin
        wr(adc_pkg::OFS_BLK0, 32'h10000000 | 32'((c << adc_pkg::BLK_CAS) | (r << adc_pkg::BLK_RCD)));
        acc(32'h10000040, r[0], ok, mux);
        chk({31'h0, ok}, 32'h1);
        chk(32'(cas_low), 32'(c + 1));
        chk(32'(rcd_clk), 32'(r + 1));
        chk({31'h0, mux}, 32'h1);
      end
    end
    wr(adc_pkg::OFS_CTRL, 32'h00002000);
    acc(32'h10000040, 1'b0, ok, mux);
    chk({31'h0, mux}, 32'h0);
    wr(adc_pkg::OFS_CTRL, 32'h0);
  endtask : t_access
  task automatic hit_case(input logic [31:0] m, input logic [31:0] a, input logic exp);
    logic ok, mux;
    wr(adc_pkg::OFS_MASK0, m);
    acc(a, 1'b0, ok, mux);
    chk({31'h0, ok}, {31'h0, exp});
  endtask : hit_case
  task automatic t_refresh();
    logic ok, mux;
    wr(adc_pkg::OFS_BLK0, 32'h10008000);
    wr(adc_pkg::OFS_BLK1, 32'h20008000);
    for (int k = 0; k < 4; k++) begin
      wr(adc_pkg::OFS_CTRL, 32'((k << adc_pkg::CTRL_RRA) | (k << adc_pkg::CTRL_RRP) | 1));
      repeat (100) @(posedge pclk);
      chk(32'(ras_gap), 32'd32);
      chk(32'(ras_low), 32'(k + 2));
    end
    chk(32'(pair_falls > 0), 32'h1);
    acc(32'h10000040, 1'b0, ok, mux);
    chk({31'h0, ok}, 32'h1);
    chk(32'(odd_edges), 32'h0);
    wr(adc_pkg::OFS_BLK1, 32'h0);
  endtask : t_refresh
  task automatic t_sync();
    logic ok, mux;
    wr(adc_pkg::OFS_CTRL, 32'h00008000);
    chk({31'h0, sync_mode}, 32'h1);
    wr(adc_pkg::OFS_CTRL, 32'h0);
    chk({31'h0, sync_mode}, 32'h1);
    acc(32'h10000040, 1'b0, ok, mux);
    chk({31'h0, ok}, 32'h0);
  endtask : t_sync
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, acc_req, acc_write} = '0;
    paddr = 12'h0;
    pwdata = 32'h0;
    acc_addr = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_port();
    t_access();
    hit_case(32'h00000000, 32'h10000040, 1'b0);
    hit_case(32'h00000001, 32'h10040000, 1'b0);
    hit_case(32'h00040001, 32'h10040000, 1'b1);
    t_refresh();
    t_sync();
    final_report();
  end
endmodule : adc_ctrl_bench
`default_nettype wire
